// ---- pcs_sequencer.sv ----
/*
 * Preset cycling sequencer: steps a preset index on a chosen advance
 * event, picks per-preset exposure and output line sources, and drives
 * three output lines. Assumes all event inputs except input_line_two
 * are single-cycle pulses from logic on core_clk.
 */
// Notes on behaviour
// RL1: Line source off leaves the output open, nothing drives it.
// RL2: Software-driven source takes the line state from the manual level.
// RL3: Exposure-start source pulses the line on every exposure begin.
// RL4: Exposure-window source follows the exposure-in-progress level.
// RL5: Latch off: manual level reaches the line at once.
// RL6: Latch on: manual level reaches the line only on the strobe command.
// RL7: Manual level active closes the output, inactive opens it.
// RL8: Preset cycling runs only while the sequencer is enabled.
// RL9: Only presets below the programmed total are used.
// RL10: The advance event select chooses what steps the index.
// RL11: Index steps only after the divider count of advance events.
// RL12: The selected rewind event returns the index to preset 1.
// RL13: Frame begin and accepted trigger are internal-synchronous sources.
// RL14: Counter one, input line two and software are external-asynchronous.
// RL15: Synchronous source: rewind waits for the next advance event.
// RL16: Asynchronous source: rewind happens at once, to preset 1.
// RL17: Exposure is stored per preset and the current preset's value applies.
// RL18: While exposure is cycled the primary exposure is read-only.
// RL19: After the last preset the index wraps to the first.
// RL20: A preset may be edited while another preset is active.
// RL21: Line sources are kept per preset and per line.
// RL22: Three output lines, each with its own control.
// RL23: Enabling starts at preset 1 with the event counter cleared.
`timescale 1ns/1ns
module pcs_sequencer
	import pcs_pkg::*;
(
	input wire logic core_clk, // 20 MHz core clock
	input wire logic sys_rst, // Async reset, active high
	input wire logic [ADDR_W-1:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	input wire logic frame_begin_event, // Frame start pulse
	input wire logic accepted_frame_trigger, // Accepted trigger pulse
	input wire logic counter_one_done, // Counter one end pulse
	input wire logic input_line_two, // External input pin level
	input wire logic acquisition_end_event, // Acquisition stop pulse
	input wire logic exposure_begin_event, // Exposure start pulse
	input wire logic exposure_window_level, // High while exposing
	output logic [EXPO_W-1:0] exposure_duration, // Exposure in use
	output logic [LINES-1:0] line_closed // 1 = output circuit closed
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic en;
		logic cyc_expo;
		logic latch;
		logic [TOTAL_W-1:0] total;
		logic [2:0] adv_sel;
		logic [DIV_W-1:0] div;
		logic [1:0] rew_sel;
		logic [IDX_W-1:0] edit;
		logic [EXPO_W-1:0] prim;
		logic [LINES-1:0] manual;
		logic [LINES-1:0] applied;
		logic [PRESETS-1:0][EXPO_W-1:0] expo;
		logic [PRESETS-1:0][LINES-1:0][SRC_W-1:0] src;
		logic [IDX_W-1:0] idx;
		logic [DIV_W-1:0] cnt;
		logic pend;
		logic [PULSE_W-1:0] pulse_cnt;
		logic l2_a;
		logic l2_b;
		logic l2_p;
		logic [31:0] rdata;
		logic [EXPO_W-1:0] expo_out;
		logic [LINES-1:0] line;
	} pcs_state_type;

	pcs_state_type s_q;
	pcs_state_type s_d;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Closed-circuit level for one line from its source
	function automatic logic line_level(
		input logic [SRC_W-1:0] src,
		input logic manual,
		input logic pulse,
		input logic window
	);
		logic lvl;
		lvl = 1'b0;
		unique case (src)
			SRC_OFF: lvl = 1'b0; // RL1
			SRC_SW: lvl = manual; // RL2 RL7
			SRC_PULSE: lvl = pulse; // RL3
			SRC_WINDOW: lvl = window; // RL4
		endcase
		return lvl;
	endfunction

	// Zero in a count register is taken as one
	function automatic logic [DIV_W-1:0] at_least_one(input logic [DIV_W-1:0] v);
		return (v == '0) ? DIV_W'(1) : v;
	endfunction

	function automatic logic is_async(input logic [2:0] sel);
		return (sel == ADV_COUNTER_ONE) || (sel == ADV_LINE_TWO) || (sel == ADV_NONE); // RL14
	endfunction

	// Next preset number, wrapping to the first after the last in use
	function automatic logic [IDX_W-1:0] step_index(
		input logic [IDX_W-1:0] idx,
		input logic [IDX_W-1:0] last
	);
		return (idx >= last) ? '0 : idx + IDX_W'(1);
	endfunction

	// True once this event completes the divider count
	function automatic logic div_reached(
		input logic [DIV_W-1:0] cnt_next,
		input logic [DIV_W-1:0] div
	);
		return cnt_next >= at_least_one(div);
	endfunction

	// Last preset in use; totals above the preset store clamp to it
	function automatic logic [IDX_W-1:0] last_index(input logic [TOTAL_W-1:0] total);
		logic [DIV_W-1:0] t;
		t = at_least_one(DIV_W'(total));
		if (t > DIV_W'(PRESETS)) begin
			t = DIV_W'(PRESETS);
		end
		return IDX_W'(t - DIV_W'(1));
	endfunction

	// Advance event as chosen by the select; codes past the last source never step
	function automatic logic advance_pick(
		input logic [2:0] sel,
		input logic frame_ev,
		input logic trig_ev,
		input logic cnt_ev,
		input logic pin_ev,
		input logic sw_ev
	);
		logic a;
		a = 1'b0;
		unique case (sel) // RL10 RL13
			ADV_FRAME_BEGIN: a = frame_ev;
			ADV_ACCEPTED_TRIG: a = trig_ev;
			ADV_COUNTER_ONE: a = cnt_ev;
			ADV_LINE_TWO: a = pin_ev;
			ADV_NONE: a = sw_ev;
			default: a = 1'b0;
		endcase
		return a;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic l2_rise;
		logic sw_adv;
		logic sw_rew;
		logic strobe;
		logic adv;
		logic rew;
		logic [DIV_W-1:0] cnt_next;
		logic [IDX_W-1:0] last_idx;
		logic pulse;

		s_d = s_q;
		l2_rise = 1'b0;
		sw_adv = 1'b0;
		sw_rew = 1'b0;
		strobe = 1'b0;
		adv = 1'b0;
		rew = 1'b0;
		cnt_next = '0;
		last_idx = '0;
		pulse = 1'b0;

		// Input pin is asynchronous, edge taken after two stages
		s_d.l2_a = input_line_two;
		s_d.l2_b = s_q.l2_a;
		s_d.l2_p = s_q.l2_b;
		l2_rise = s_q.l2_b & ~s_q.l2_p;

		// --------------------------------------------------------
		// Register writes
		// --------------------------------------------------------
		if (reg_wr) begin
			unique case (reg_addr)
				REG_CTRL: begin
					s_d.en = reg_wdata[CTRL_EN_BIT];
					s_d.cyc_expo = reg_wdata[CTRL_CYC_EXPO_BIT];
					s_d.latch = reg_wdata[CTRL_LATCH_BIT];
				end
				REG_TOTAL: s_d.total = reg_wdata[TOTAL_W-1:0];
				REG_ADV_SEL: s_d.adv_sel = reg_wdata[2:0];
				REG_ADV_DIV: s_d.div = reg_wdata[DIV_W-1:0];
				REG_REW_SEL: s_d.rew_sel = reg_wdata[1:0];
				REG_CMD: begin
					sw_adv = reg_wdata[CMD_ADV_BIT];
					sw_rew = reg_wdata[CMD_REWIND_BIT];
					strobe = reg_wdata[CMD_STROBE_BIT];
				end
				REG_EDIT: s_d.edit = reg_wdata[IDX_W-1:0];
				// Any preset may be edited while another is active
				REG_EXPO_PRESET: s_d.expo[s_q.edit] = reg_wdata[EXPO_W-1:0]; // RL17 RL20
				REG_LINE_SRC: begin
					// Pick codes beyond the last line are ignored
					if (reg_wdata[LINE_PICK_LSB +: 2] < 2'(LINES)) begin // RL22
						s_d.src[s_q.edit][reg_wdata[LINE_PICK_LSB +: 2]] =
							reg_wdata[LINE_SRC_LSB +: SRC_W]; // RL21 RL20
					end
				end
				REG_MANUAL: s_d.manual = reg_wdata[LINES-1:0];
				REG_EXPO_PRIMARY: begin
					if (!s_q.cyc_expo) begin // RL18
						s_d.prim = reg_wdata[EXPO_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// --------------------------------------------------------
		// Register reads
		// --------------------------------------------------------
		s_d.rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: begin
					s_d.rdata[CTRL_EN_BIT] = s_q.en;
					s_d.rdata[CTRL_CYC_EXPO_BIT] = s_q.cyc_expo;
					s_d.rdata[CTRL_LATCH_BIT] = s_q.latch;
				end
				REG_TOTAL: s_d.rdata[TOTAL_W-1:0] = s_q.total;
				REG_ADV_SEL: s_d.rdata[2:0] = s_q.adv_sel;
				REG_ADV_DIV: s_d.rdata[DIV_W-1:0] = s_q.div;
				REG_REW_SEL: s_d.rdata[1:0] = s_q.rew_sel;
				REG_EDIT: s_d.rdata[IDX_W-1:0] = s_q.edit;
				REG_EXPO_PRESET: s_d.rdata[EXPO_W-1:0] = s_q.expo[s_q.edit];
				REG_LINE_SRC: s_d.rdata[LINES*SRC_W-1:0] = s_q.src[s_q.edit];
				REG_MANUAL: s_d.rdata[LINES-1:0] = s_q.manual;
				REG_EXPO_PRIMARY: s_d.rdata[EXPO_W-1:0] = s_q.prim;
				REG_STATUS: begin
					s_d.rdata[STAT_IDX_LSB +: IDX_W] = s_q.idx;
					s_d.rdata[STAT_PEND_BIT] = s_q.pend;
					s_d.rdata[STAT_CNT_LSB +: DIV_W] = s_q.cnt;
				end
				REG_EXPO_APPLIED: s_d.rdata[EXPO_W-1:0] = s_q.expo_out;
				default: s_d.rdata = '0;
			endcase
		end

		// --------------------------------------------------------
		// Advance and rewind events
		// --------------------------------------------------------
		adv = advance_pick(s_q.adv_sel, frame_begin_event, accepted_frame_trigger,
			counter_one_done, l2_rise, sw_adv); // RL10 RL13

		unique case (s_q.rew_sel) // RL12
			REW_NONE: rew = 1'b0;
			REW_ACQ_END: rew = acquisition_end_event;
			REW_LINE_TWO: rew = l2_rise;
			REW_COUNTER_ONE: rew = counter_one_done;
		endcase
		rew = rew | sw_rew;

		// --------------------------------------------------------
		// Preset index
		// --------------------------------------------------------
		last_idx = last_index(s_q.total); // RL9
		cnt_next = s_q.cnt + DIV_W'(1);

		if (!s_q.en) begin
			// Held at preset 1 so enabling starts clean
			s_d.idx = '0; // RL8 RL23
			s_d.cnt = '0; // RL23
			s_d.pend = 1'b0;
		end else if (is_async(s_q.adv_sel)) begin
			// A rewind still pending from sync mode is not kept for later
			if (rew || s_q.pend) begin
				s_d.idx = '0; // RL16
				s_d.cnt = '0;
				s_d.pend = 1'b0;
			end else if (adv) begin
				if (div_reached(cnt_next, s_q.div)) begin // RL11
					s_d.cnt = '0;
					s_d.idx = step_index(s_q.idx, last_idx); // RL19
				end else begin
					s_d.cnt = cnt_next;
				end
			end
		end else begin
			if (adv) begin
				if (s_q.pend || rew) begin
					// Deferred rewind is carried out on this event
					s_d.idx = '0; // RL15
					s_d.cnt = '0;
					s_d.pend = 1'b0;
				end else if (div_reached(cnt_next, s_q.div)) begin // RL11
					s_d.cnt = '0;
					s_d.idx = step_index(s_q.idx, last_idx); // RL19
				end else begin
					s_d.cnt = cnt_next;
				end
			end else if (rew) begin
				s_d.pend = 1'b1; // RL15
			end
		end

		// Index can sit above a newly lowered total; pull it back
		if (s_q.en && (s_q.idx > last_idx)) begin
			s_d.idx = '0; // RL9
			s_d.cnt = '0;
		end

		// --------------------------------------------------------
		// Exposure in use
		// --------------------------------------------------------
		s_d.expo_out = s_q.cyc_expo ? s_q.expo[s_q.idx] : s_q.prim; // RL17 RL18

		// --------------------------------------------------------
		// Output lines
		// --------------------------------------------------------
		if (!s_q.latch) begin
			s_d.applied = s_q.manual; // RL5
		end else if (strobe) begin
			s_d.applied = s_q.manual; // RL6
		end

		// Retrigger restarts the pulse so close exposures each get a full flash
		if (exposure_begin_event) begin
			s_d.pulse_cnt = PULSE_W'(STROBE_PULSE_CYC); // RL3
		end else if (s_q.pulse_cnt != '0) begin
			s_d.pulse_cnt = s_q.pulse_cnt - PULSE_W'(1);
		end
		pulse = exposure_begin_event | (s_q.pulse_cnt > PULSE_W'(1));

		// Lines register their level, one cycle behind the sources
		for (int i = 0; i < LINES; i++) begin
			s_d.line[i] = line_level(s_q.src[s_q.idx][i], s_q.applied[i], pulse,
				exposure_window_level); // RL4 RL21 RL22
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign exposure_duration = s_q.expo_out;
	assign line_closed = s_q.line;

endmodule

// ---- pcs_pkg.sv ----
/*
 * Shared constants for the preset cycling sequencer: register offsets,
 * field positions, select codes and timing counts.
 * Assumes a 20 MHz core clock and a simple strobed register port.
 */
package pcs_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int STROBE_PULSE_NS = 1000;
	// Least time, so round up
	localparam int STROBE_PULSE_CYC =
		(STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int PRESETS = 16;
	localparam int IDX_W = 4;
	localparam int TOTAL_W = 5;
	localparam int DIV_W = 16;
	localparam int EXPO_W = 24;
	localparam int LINES = 3;
	localparam int SRC_W = 2;
	localparam int PULSE_W = 5;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TOTAL = 8'h04;
	localparam logic [7:0] REG_ADV_SEL = 8'h08;
	localparam logic [7:0] REG_ADV_DIV = 8'h0C;
	localparam logic [7:0] REG_REW_SEL = 8'h10;
	localparam logic [7:0] REG_CMD = 8'h14;
	localparam logic [7:0] REG_EDIT = 8'h18;
	localparam logic [7:0] REG_EXPO_PRESET = 8'h1C;
	localparam logic [7:0] REG_LINE_SRC = 8'h20;
	localparam logic [7:0] REG_MANUAL = 8'h24;
	localparam logic [7:0] REG_EXPO_PRIMARY = 8'h28;
	localparam logic [7:0] REG_STATUS = 8'h2C;
	localparam logic [7:0] REG_EXPO_APPLIED = 8'h30;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CYC_EXPO_BIT = 1;
	localparam int CTRL_LATCH_BIT = 2;
	localparam int CMD_ADV_BIT = 0;
	localparam int CMD_REWIND_BIT = 1;
	localparam int CMD_STROBE_BIT = 2;
	localparam int LINE_PICK_LSB = 0;
	localparam int LINE_SRC_LSB = 4;
	localparam int STAT_IDX_LSB = 0;
	localparam int STAT_PEND_BIT = 4;
	localparam int STAT_CNT_LSB = 8;

	// ------------------------------------------------------------
	// Select codes and reset values
	// ------------------------------------------------------------
	localparam logic [2:0] ADV_FRAME_BEGIN = 3'h0;
	localparam logic [2:0] ADV_ACCEPTED_TRIG = 3'h1;
	localparam logic [2:0] ADV_COUNTER_ONE = 3'h2;
	localparam logic [2:0] ADV_LINE_TWO = 3'h3;
	localparam logic [2:0] ADV_NONE = 3'h4;

	localparam logic [1:0] REW_NONE = 2'h0;
	localparam logic [1:0] REW_ACQ_END = 2'h1;
	localparam logic [1:0] REW_LINE_TWO = 2'h2;
	localparam logic [1:0] REW_COUNTER_ONE = 2'h3;

	localparam logic [1:0] SRC_OFF = 2'h0;
	localparam logic [1:0] SRC_SW = 2'h1;
	localparam logic [1:0] SRC_PULSE = 2'h2;
	localparam logic [1:0] SRC_WINDOW = 2'h3;

	localparam logic [4:0] TOTAL_RST = 5'h01;
	localparam logic [15:0] DIV_RST = 16'h0001;

endpackage

// ---- pcs_props.sv ----
/* Port checker for pcs_sequencer.
   Assumes software keeps the register port rules; bound in below. */
`timescale 1ns/1ns
module pcs_props
	import pcs_pkg::*;
(
	input wire logic core_clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic [ADDR_W-1:0] reg_addr, // Address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write
	input wire logic reg_rd, // Read
	input wire logic [31:0] reg_rdata, // Read data
	input wire logic exposure_begin_event, // Exposure start
	input wire logic exposure_window_level, // Exposing
	input wire logic [EXPO_W-1:0] exposure_duration, // Exposure
	input wire logic [LINES-1:0] line_closed // Lines
);
	// --------
	// Shadow of control, manual level, total, edit select and preset 1 line setup
	// --------
	logic [2:0] ctl_q, man_q, off_m, sw_m, pls_m, win_m;
	logic [4:0] tot_q, tot_eff;
	logic [3:0] edit_q;
	logic [5:0] src_q;
	logic [1:0] quiet_q;
	logic cfg_ok;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_q <= 3'h0;
			man_q <= 3'h0;
			tot_q <= 5'h00;
			edit_q <= 4'h0;
			src_q <= 6'h00;
			quiet_q <= 2'h0;
		end else begin
			// Manual writes keep the count so their direct effect stays watched
			if (reg_wr && reg_addr != REG_MANUAL) begin
				quiet_q <= 2'h0;
			end else if (quiet_q != 2'h3) begin
				quiet_q <= quiet_q + 2'h1;
			end
			if (reg_wr) begin
				case (reg_addr)
				REG_CTRL: ctl_q <= reg_wdata[2:0];
				REG_MANUAL: man_q <= reg_wdata[2:0];
				REG_TOTAL: tot_q <= reg_wdata[4:0];
				REG_EDIT: edit_q <= reg_wdata[3:0];
				REG_LINE_SRC: begin
					if (edit_q == 4'h0 && reg_wdata[1:0] != 2'h3) begin
						src_q[2*reg_wdata[1:0] +: 2] <= reg_wdata[5:4];
					end
				end
				default: ;
				endcase
			end
		end
	end
	always_comb begin
		tot_eff = (tot_q == 5'h00) ? 5'h01 : ((tot_q > 5'h10) ? 5'h10 : tot_q);
		for (int i = 0; i < LINES; i++) begin
			off_m[i] = src_q[2*i +: 2] == SRC_OFF;
			sw_m[i] = src_q[2*i +: 2] == SRC_SW;
			pls_m[i] = src_q[2*i +: 2] == SRC_PULSE;
			win_m[i] = src_q[2*i +: 2] == SRC_WINDOW;
		end
		// Disabled lines use preset 1; three quiet cycles let a write settle
		cfg_ok = quiet_q == 2'h3 && !ctl_q[CTRL_EN_BIT];
	end
	// --------
	// Assertions
	// --------
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_reset_outs_zero: assert property ($past(sys_rst) |->
		exposure_duration == 24'h000000 && line_closed == 3'h0)
		else $error("Outputs not zero after reset");
	a_disabled_idle: assert property (cfg_ok && $past(reg_rd && reg_addr == REG_STATUS) |->
		reg_rdata == 32'h0)
		else $error("Status not idle while disabled");
	a_idx_within: assert property (quiet_q == 2'h3 && $past(reg_rd && reg_addr == REG_STATUS)
		|-> {1'b0, reg_rdata[3:0]} < tot_eff)
		else $error("Index beyond preset total");
	a_off_open: assert property (cfg_ok |-> (line_closed & off_m) == 3'h0)
		else $error("Line closed with source off");
	a_window_follow: assert property (cfg_ok |->
		(line_closed & win_m) == ({3{$past(exposure_window_level)}} & win_m))
		else $error("Line does not follow exposure window");
	a_sw_direct: assert property (cfg_ok && !ctl_q[CTRL_LATCH_BIT] |->
		(line_closed & sw_m) == ($past(man_q, 2) & sw_m))
		else $error("Line does not follow manual level");
	a_latch_hold: assert property (cfg_ok && ctl_q[CTRL_LATCH_BIT] |->
		$stable(line_closed & sw_m))
		else $error("Latched line moved without strobe");
	a_pulse_start: assert property (cfg_ok && $past(exposure_begin_event) |->
		(line_closed & pls_m) == pls_m)
		else $error("No pulse after exposure start");
endmodule
bind pcs_sequencer pcs_props u_props (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .exposure_begin_event, .exposure_window_level, .exposure_duration,
	.line_closed);

// ---- pcs_strobe_model.sv ----
/* Frame trigger source and strobe light model.
   Assumes go is a one-cycle pulse and frames do not overlap. */
`timescale 1ns/1ns
module pcs_strobe_model (
	input wire logic core_clk, // Clock
	input wire logic go, // Start a frame
	input wire logic [7:0] exp_len, // Exposure cycles
	input wire logic strobe_in, // Line wired to the light
	output logic frame_begin_event, // Frame start
	output logic exposure_begin_event, // Exposure start
	output logic exposure_window_level, // Exposing
	output logic [7:0] flash_cnt // Flashes fired
);
	logic [7:0] left = 8'h00;
	logic strobe_q = 1'b0;
	initial begin
		frame_begin_event = 1'b0;
		exposure_begin_event = 1'b0;
		exposure_window_level = 1'b0;
		flash_cnt = 8'h00;
	end
	always @(posedge core_clk) begin
		frame_begin_event <= go;
		exposure_begin_event <= frame_begin_event;
		if (frame_begin_event) begin
			left <= exp_len;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end
		exposure_window_level <= frame_begin_event || left > 8'h01;
		strobe_q <= strobe_in;
		// The light fires once per closing edge
		if (strobe_in && !strobe_q) begin
			flash_cnt <= flash_cnt + 8'h01;
		end
	end
endmodule

// ---- tb_pcs.sv ----
/* Self-checking bench for pcs_sequencer with a strobe light model.
   Assumes pcs_props is bound in by its own file. */
`timescale 1ns/1ns
module testbench;
	import pcs_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic go = 1'b0;
	logic accepted_frame_trigger = 1'b0;
	logic counter_one_done = 1'b0;
	logic input_line_two = 1'b0;
	logic acquisition_end_event = 1'b0;
	logic frame_begin_event, exposure_begin_event, exposure_window_level;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] exp_len = 8'h06;
	logic [7:0] flash_cnt;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata, rd_v;
	logic [31:0] rnd = 32'h000132DD;
	logic [EXPO_W-1:0] exposure_duration;
	logic [EXPO_W-1:0] expo [4];
	logic [LINES-1:0] line_closed;
	logic [2:0] rew_ev [4] = '{3'h0, 3'h5, ADV_LINE_TWO, ADV_COUNTER_ONE};
	int err_total = 0;
	int checks_done = 0;
	always #25 core_clk = ~core_clk;
	pcs_sequencer DUT (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.frame_begin_event, .accepted_frame_trigger, .counter_one_done, .input_line_two,
		.acquisition_end_event, .exposure_begin_event, .exposure_window_level,
		.exposure_duration, .line_closed);
	pcs_strobe_model u_light (.core_clk, .go, .exp_len, .strobe_in(line_closed[1]),
		.frame_begin_event, .exposure_begin_event, .exposure_window_level, .flash_cnt);
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] stat_word(input logic [3:0] idx, input logic pend,
		input logic [15:0] cnt);
		return {8'h00, cnt, 3'h0, pend, idx};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("Checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask
	// Code 5 stands for the acquisition end event
	task automatic ev(input logic [2:0] code);
		@(posedge core_clk);
		case (code)
		ADV_FRAME_BEGIN: go <= 1'b1;
		ADV_ACCEPTED_TRIG: accepted_frame_trigger <= 1'b1;
		ADV_COUNTER_ONE: counter_one_done <= 1'b1;
		ADV_LINE_TWO: input_line_two <= 1'b1;
		3'h5: acquisition_end_event <= 1'b1;
		default: wr(REG_CMD, 32'h1);
		endcase
		@(posedge core_clk);
		{go, accepted_frame_trigger, counter_one_done, input_line_two} <= 4'h0;
		acquisition_end_event <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask
	initial begin
		repeat (100000) @(posedge core_clk);
		err_total++;
		summarize;
	end
	initial begin
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(REG_STATUS);
		chk(rd_v, 32'h0);
		rd(8'hFC);
		chk(rd_v, 32'h0);
		wr(REG_TOTAL, 32'h4);
		wr(REG_ADV_SEL, {29'h0, ADV_COUNTER_ONE});
		for (int i = 0; i < 4; i++) begin
			rnd = nxt(rnd);
			expo[i] = rnd[EXPO_W-1:0];
			wr(REG_EDIT, 32'(i));
			wr(REG_EXPO_PRESET, {8'h00, expo[i]});
		end
		wr(REG_EXPO_PRIMARY, 32'h55);
		wr(REG_CTRL, 32'h3);
		wr(REG_EXPO_PRIMARY, 32'hAA);
		repeat (3) @(posedge core_clk);
		chk({8'h00, exposure_duration}, {8'h00, expo[0]});
		for (int k = 1; k < 10; k++) begin
			if (k == 5) begin
				expo[2] = ~expo[2];
				wr(REG_EDIT, 32'h2);
				wr(REG_EXPO_PRESET, {8'h00, expo[2]});
			end
			ev(ADV_COUNTER_ONE);
			chk({8'h00, exposure_duration}, {8'h00, expo[k % 4]});
		end
		wr(REG_CTRL, 32'h1);
		repeat (3) @(posedge core_clk);
		chk({8'h00, exposure_duration}, 32'h55);
		rd(REG_EXPO_PRIMARY);
		chk(rd_v, 32'h55);
		rd(REG_EXPO_APPLIED);
		chk(rd_v, 32'h55);
		wr(REG_CMD, 32'h2);
		wr(REG_ADV_DIV, 32'h3);
		ev(ADV_COUNTER_ONE);
		ev(ADV_COUNTER_ONE);
		rd(REG_STATUS);
		chk(rd_v, stat_word(4'h0, 1'b0, 16'h0002));
		ev(ADV_COUNTER_ONE);
		rd(REG_STATUS);
		chk(rd_v, 32'h1);
		wr(REG_ADV_DIV, 32'h1);
		for (int r = 1; r < 4; r++) begin
			wr(REG_REW_SEL, 32'(r));
			ev(rew_ev[r]);
			rd(REG_STATUS);
			chk(rd_v, 32'h0);
			wr(REG_REW_SEL, 32'h0);
			ev(ADV_COUNTER_ONE);
		end
		for (int a = 0; a < 5; a++) begin
			wr(REG_ADV_SEL, 32'(a));
			ev(3'(a));
			rd(REG_STATUS);
			chk(rd_v, 32'h2);
			wr(REG_CMD, 32'h2);
			rd(REG_STATUS);
			chk(rd_v, (a < 2) ? 32'h12 : 32'h0);
			if (a < 2) begin
				ev(3'(a));
			end
			rd(REG_STATUS);
			chk(rd_v, 32'h0);
			ev(3'(a));
		end
		wr(REG_CTRL, 32'h0);
		wr(REG_EDIT, 32'h0);
		wr(REG_LINE_SRC, 32'h10);
		wr(REG_LINE_SRC, 32'h21);
		wr(REG_LINE_SRC, 32'h32);
		wr(REG_LINE_SRC, 32'h03);
		rd(REG_LINE_SRC);
		chk(rd_v, 32'h39);
		for (int m = 0; m < 4; m++) begin
			rnd = nxt(rnd);
			wr(REG_MANUAL, rnd & 32'h7);
			repeat (3) @(posedge core_clk);
			chk({31'h0, line_closed[0]}, {31'h0, rnd[0]});
			exp_len <= 8'h03 + {4'h0, rnd[7:4]};
			ev(ADV_FRAME_BEGIN);
			chk({31'h0, line_closed[2]}, {31'h0, exp_len > 8'h03});
			repeat (25) @(posedge core_clk);
		end
		chk({24'h0, flash_cnt}, 32'h4);
		rd(REG_STATUS);
		chk(rd_v, stat_word(4'h0, 1'b0, 16'h0000));
		wr(REG_MANUAL, 32'h0);
		wr(REG_CTRL, 32'h4);
		wr(REG_MANUAL, 32'h1);
		repeat (3) @(posedge core_clk);
		chk({31'h0, line_closed[0]}, 32'h0);
		wr(REG_CMD, 32'h4);
		repeat (3) @(posedge core_clk);
		chk({31'h0, line_closed[0]}, 32'h1);
		wr(REG_LINE_SRC, 32'h00);
		repeat (5) @(posedge core_clk);
		chk({31'h0, line_closed[0]}, 32'h0);
		summarize;
	end
endmodule
